// ==== rtl/tsh_pkg.sv ====
// Package for the timed sleep and halt controller: constants and states.
// Assumes a single 20 MHz clock; all timing counts derive from it.
//
// Function
// - Accept sleep seconds 1 to 65535
// - Round sleep up to 2.304 s steps
// - Sleeping pins keep their prior directions
// - Each wake forces pins input 18 ms
// - After glitch restore program pin directions
// - Each wake advances counter once per credited step, else resleep
// - Calibrate watchdog against resonator, apply correction
// - Halt stops execution until reset
// - Halt stays at full run power
// - Halt holds pins, never glitches
package tsh_pkg;
   localparam int unsigned CLK_HZ = 20_000_000; // Device clock rate
   localparam int unsigned NPINS = 16; // Number of I/O pins
   localparam int unsigned SEC_W = 16; // Width of sleep operand
   // Watchdog step in microseconds, nominal 2.304 s
   localparam longint unsigned STEP_US = 64'd2_304_000;
   // Glitch time in microseconds, 18 ms
   localparam longint unsigned GLITCH_US = 64'd18_000;
   // Cycles per nominal watchdog step
   localparam longint unsigned STEP_CYC = STEP_US * CLK_HZ / 1_000_000;
   // Cycles of the input-mode glitch
   localparam longint unsigned GLITCH_CYC = GLITCH_US * CLK_HZ / 1_000_000;
   // Steps in ms units so a second count can be turned into steps
   localparam logic [31:0] STEP_MS = 32'd2304;
   localparam logic [31:0] MS_PER_S = 32'd1000;
   localparam int unsigned STEPS_W = 16; // Step counter width
   // Calibration count width: the nominal step is over 2^25 cycles, so
   // one spare bit is left for a slow oscillator's longer period
   localparam int unsigned CORR_W = 27;
   // Controller states
   typedef enum logic [2:0] {
      TSH_RUN, TSH_DIVIDE, TSH_SLEEP, TSH_GLITCH, TSH_HALT
   } tsh_state_t;
endpackage : tsh_pkg

// ==== rtl/tsh_ctrl.sv ====
// Sleep and halt controller: timed low-power sleep counted in watchdog
// steps, periodic wake glitch, and a halt state held until reset.
// Assumes the core issues one-cycle command pulses and that the watchdog
// oscillator arrives as a synchronous one-cycle tick.
// Assumes reset is already synchronous and comes from the external pin
// or from a power-on circuit; it is the only way out of halt.
`timescale 1ns/10ps
`default_nettype none
module tsh_ctrl #(
   parameter longint unsigned STEP_CYCLES = tsh_pkg::STEP_CYC,
   parameter longint unsigned GLITCH_CYCLES = tsh_pkg::GLITCH_CYC
) (
   input wire logic i_clock,
   input wire logic i_rst, // Also driven from external_reset_pin_n
   input wire logic i_sleep_cmd, // One-cycle sleep request
   input wire logic [tsh_pkg::SEC_W-1:0] i_sleep_secs,
   input wire logic i_halt_cmd, // One-cycle halt request
   input wire logic i_wdt_tick, // Watchdog oscillator timeout pulse
   input wire logic [tsh_pkg::NPINS-1:0] i_prog_dir, // 1 = output
   output logic [tsh_pkg::NPINS-1:0] o_pin_dir,
   output logic o_low_power,
   output logic o_exec_en,
   output logic o_sleep_done, // Pulse on resume
   output logic o_halted
);
   import tsh_pkg::*;

   // Glitch and step lengths in device clock cycles. Both are parameters
   // so a bench can shrink them; the real values make a glitch last
   // hundreds of thousands of cycles, which is also what lets one wake
   // absorb several credited steps.
   localparam logic [31:0] GL_N = 32'(GLITCH_CYCLES);
   localparam logic [CORR_W-1:0] STEP_N = CORR_W'(STEP_CYCLES);

   tsh_state_t state_q, state_d; // Main state
   logic [STEPS_W-1:0] target_q, target_d; // Steps requested
   logic [STEPS_W-1:0] elapsed_q, elapsed_d; // Steps done
   logic [31:0] gl_cnt_q, gl_cnt_d; // Glitch timer
   logic [31:0] dividend_q, dividend_d; // Milliseconds to divide
   logic [NPINS-1:0] dir_q, dir_d; // Latched pin directions
   // Low-power request; drops for every wake glitch
   logic low_q, low_d;
   // Execution enable; low while dividing, sleeping or halted
   logic exec_q, exec_d;
   // One-cycle resume pulse
   logic done_q, done_d;
   // Halt flag; cleared only by reset
   logic halt_q, halt_d;
   // Pin directions as driven out; all input for the whole glitch
   logic [NPINS-1:0] pin_dir_q, pin_dir_d;
   // Calibration: cycles counted between two watchdog ticks while running
   logic [CORR_W-1:0] cal_cnt_q, cal_cnt_d;
   logic [CORR_W-1:0] wdt_per_q, wdt_per_d; // Measured watchdog period
   // Correction accumulator: resonator cycles credited per watchdog tick
   logic [CORR_W:0] credit_q, credit_d;

   // Next-state logic for the whole controller
   always_comb begin
      state_d = state_q;
      target_d = target_q;
      elapsed_d = elapsed_q;
      gl_cnt_d = gl_cnt_q;
      dividend_d = dividend_q;
      dir_d = dir_q;
      low_d = low_q;
      exec_d = exec_q;
      done_d = 1'b0;
      halt_d = halt_q;
      cal_cnt_d = cal_cnt_q;
      wdt_per_d = wdt_per_q;
      credit_d = credit_q;
      unique case (state_q)
         TSH_RUN: begin
            // Pins follow the program while running
            dir_d = i_prog_dir;
            exec_d = 1'b1;
            // Measure watchdog period in resonator cycles while awake
            if (i_wdt_tick) begin
               if (cal_cnt_q != '0) begin
                  wdt_per_d = cal_cnt_q;
               end
               cal_cnt_d = CORR_W'(1);
            end else if (cal_cnt_q != '0 && cal_cnt_q != '1) begin
               // Count only once a first tick has opened the window, so
               // the time since reset or resume is never taken as a period
               cal_cnt_d = cal_cnt_q + CORR_W'(1);
            end
            if (i_halt_cmd) begin
               // Halt: no low power, pins frozen
               state_d = TSH_HALT;
               exec_d = 1'b0;
               halt_d = 1'b1;
            end else if (i_sleep_cmd && i_sleep_secs != '0) begin
               dividend_d = 32'(i_sleep_secs) * MS_PER_S;
               target_d = '0;
               elapsed_d = '0;
               credit_d = '0;
               exec_d = 1'b0;
               state_d = TSH_DIVIDE;
            end
         end
         TSH_DIVIDE: begin
            // Ceiling division of milliseconds by the step, one step a cycle
            if (dividend_q != '0) begin
               target_d = target_q + STEPS_W'(1);
               dividend_d = (dividend_q > STEP_MS) ? dividend_q - STEP_MS
                                                   : 32'h0000_0000;
            end else begin
               state_d = TSH_SLEEP;
               low_d = 1'b1;
               dir_d = i_prog_dir;
            end
         end
         TSH_SLEEP: begin
            // Directions stay as latched; only the glitch overrides them
            if (i_wdt_tick) begin
               low_d = 1'b0;
               gl_cnt_d = '0;
               state_d = TSH_GLITCH;
               // Credit the measured period; a step counts when a nominal
               // step of time has been covered, so a fast oscillator waits
               // for extra ticks and a slow one is never short-changed.
               credit_d = credit_q + {1'b0, wdt_per_q};
            end
         end
         TSH_GLITCH: begin
            // Spend one credited step per glitch cycle, so a slow
            // oscillator whose tick covers several steps is counted in
            // full rather than as a single step per wake.
            if (credit_q >= {1'b0, STEP_N} && elapsed_q < target_q) begin
               credit_d = credit_q - {1'b0, STEP_N};
               elapsed_d = elapsed_q + STEPS_W'(1);
            end
            if (gl_cnt_q >= GL_N - 32'd1) begin
               // Control regained: resume once the target is reached
               if (elapsed_d >= target_q) begin
                  state_d = TSH_RUN;
                  exec_d = 1'b1;
                  done_d = 1'b1;
                  dir_d = i_prog_dir;
                  cal_cnt_d = '0;
               end else begin
                  // Not yet: back to low power until the next tick
                  state_d = TSH_SLEEP;
                  low_d = 1'b1;
               end
            end else begin
               gl_cnt_d = gl_cnt_q + 32'd1;
            end
         end
         TSH_HALT: begin
            // Only reset leaves; power and pins stay as they are
            exec_d = 1'b0;
            low_d = 1'b0;
            dir_d = dir_q;
         end
         default: state_d = TSH_RUN;
      endcase
      // Pins read as inputs for the whole glitch, otherwise as latched;
      // decided from the next state so the pins switch with the state
      pin_dir_d = (state_d == TSH_GLITCH) ? '0 : dir_d;
   end

   // Register stage; reset is how a halt is left
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_q <= TSH_RUN;
         target_q <= '0;
         elapsed_q <= '0;
         gl_cnt_q <= '0;
         dividend_q <= '0;
         dir_q <= '0;
         low_q <= 1'b0;
         exec_q <= 1'b0;
         done_q <= 1'b0;
         halt_q <= 1'b0;
         cal_cnt_q <= '0;
         wdt_per_q <= STEP_N;
         credit_q <= '0;
      end else begin
         state_q <= state_d;
         target_q <= target_d;
         elapsed_q <= elapsed_d;
         gl_cnt_q <= gl_cnt_d;
         dividend_q <= dividend_d;
         dir_q <= dir_d;
         low_q <= low_d;
         exec_q <= exec_d;
         done_q <= done_d;
         halt_q <= halt_d;
         cal_cnt_q <= cal_cnt_d;
         wdt_per_q <= wdt_per_d;
         credit_q <= credit_d;
      end
   end

   // Pin direction register; all inputs while reset holds the device
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         // Released pins are safest as inputs until the program runs
         pin_dir_q <= '0;
      end else begin
         pin_dir_q <= pin_dir_d;
      end
   end

   // Every output comes straight from a register, so loads never see
   // a combinational glitch between states
   assign o_pin_dir = pin_dir_q;
   assign o_low_power = low_q;
   assign o_exec_en = exec_q;
   assign o_sleep_done = done_q;
   assign o_halted = halt_q;
endmodule : tsh_ctrl
`default_nettype wire

// ==== tb/tsh_ctrl_properties.sv ====
// Checker for the sleep and halt controller, bound to its ports.
// Assumes the bench uses GLITCH_CYCLES of 5 and changes i_prog_dir only while running, between sleeps.
`timescale 1ns/10ps
`default_nettype none
module tsh_ctrl_props (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_sleep_cmd,
   input wire logic [15:0] i_sleep_secs,
   input wire logic i_halt_cmd,
   input wire logic i_wdt_tick,
   input wire logic [15:0] i_prog_dir,
   input wire logic [15:0] o_pin_dir,
   input wire logic o_low_power,
   input wire logic o_exec_en,
   input wire logic o_sleep_done,
   input wire logic o_halted
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Wake tick seen while asleep
   logic wake;
   assign wake = o_low_power && i_wdt_tick;
   a_halt_stops_exec: assert property (
      i_halt_cmd && o_exec_en |=> o_halted && !o_exec_en)
      else $error("halt not taken");
   a_halt_stays_put: assert property (
      o_halted |=> o_halted && !o_exec_en)
      else $error("halt left");
   a_halt_full_power: assert property (
      o_halted |-> !o_low_power)
      else $error("halt in low power");
   a_halt_no_glitch: assert property (
      o_halted && $past(o_halted) |-> $stable(o_pin_dir))
      else $error("halt pin change");
   // Five cycles is GLITCH_CYCLES at the bench value
   a_glitch_all_input: assert property (
      wake |=> (o_pin_dir == 16'h0000)[*5])
      else $error("no glitch");
   a_sleep_keeps_dir: assert property (
      o_low_power |-> o_pin_dir == i_prog_dir)
      else $error("sleep dir lost");
   a_wake_then_back: assert property (
      wake |-> ##6 (o_pin_dir == i_prog_dir
                    && (o_low_power ^ o_sleep_done)))
      else $error("bad wake end");
   a_sleep_goes_low: assert property (
      i_sleep_cmd && o_exec_en && !i_halt_cmd && i_sleep_secs != 16'h0000
      |=> !o_exec_en ##[1:40] o_low_power)
      else $error("sleep not entered");
   a_done_resumes: assert property (
      o_sleep_done |-> o_exec_en ##1 !o_sleep_done)
      else $error("bad resume");
   c_halt: cover property (o_halted);
   c_resume: cover property (o_sleep_done);
   c_glitch: cover property (wake);
endmodule : tsh_ctrl_props
bind tsh_ctrl tsh_ctrl_props chk_u (.i_clock(i_clock), .i_rst(i_rst),
   .i_sleep_cmd(i_sleep_cmd), .i_sleep_secs(i_sleep_secs),
   .i_halt_cmd(i_halt_cmd), .i_wdt_tick(i_wdt_tick), .i_prog_dir(i_prog_dir),
   .o_pin_dir(o_pin_dir), .o_low_power(o_low_power), .o_exec_en(o_exec_en),
   .o_sleep_done(o_sleep_done), .o_halted(o_halted));
`default_nettype wire

// ==== tb/tsh_ext.sv ====
// External reset pin model: power-on low, then pulled up; a press pulls low.
// Assumes the bench asks for a press by holding i_press over two falling edges.
`timescale 1ns/10ps
`default_nettype none
module tsh_ext (
   input wire logic i_clock,
   input wire logic i_press,
   output logic o_rst
);
   logic external_reset_pin_n; // Pulled high when released
   int hold = 4; // Low cycles left, power-on first
   // Drive low then let the pull-up win, off the sampling edge
   always @(negedge i_clock) begin
      if (i_press) hold = 4;
      external_reset_pin_n = (hold == 0);
      if (hold > 0) hold--;
   end
   assign o_rst = !external_reset_pin_n;
endmodule : tsh_ext
`default_nettype wire

// ==== tb/timed_sleep_and_halt_control_tb.sv ====
// Bench: sleeps of many lengths counted in wake ticks, calibration, halt.
// Assumes short STEP_CYCLES and GLITCH_CYCLES; the checker judges pins.
`timescale 1ns/10ps
`default_nettype none
module timed_sleep_and_halt_control_tb;
   logic i_clock, i_rst, i_sleep_cmd, i_halt_cmd, i_wdt_tick, press;
   logic [15:0] i_sleep_secs, i_prog_dir, o_pin_dir;
   logic o_low_power, o_exec_en, o_sleep_done, o_halted;
   int fail_count = 0, tests_run = 0, seed = 32'he551;
   int secs_q[$] = '{1, 2, 3, 4, 5, 10};
   tsh_ctrl #(.STEP_CYCLES(100), .GLITCH_CYCLES(5)) dut_u (.i_clock(i_clock),
      .i_rst(i_rst), .i_sleep_cmd(i_sleep_cmd), .i_sleep_secs(i_sleep_secs),
      .i_halt_cmd(i_halt_cmd), .i_wdt_tick(i_wdt_tick),
      .i_prog_dir(i_prog_dir), .o_pin_dir(o_pin_dir),
      .o_low_power(o_low_power), .o_exec_en(o_exec_en),
      .o_sleep_done(o_sleep_done), .o_halted(o_halted));
   tsh_ext ext_u (.i_clock(i_clock), .i_press(press), .o_rst(i_rst));
   initial begin
      i_clock = 0;
      forever #25 i_clock = ~i_clock;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask : check
   task test_done;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask : cyc
   task tick;
      i_wdt_tick = 1;
      cyc(1);
      i_wdt_tick = 0;
   endtask : tick
   // Sleep s seconds; count wake ticks until execution resumes
   task sleep_for(input int s, input int per_tick);
      int n, w, exp_n;
      i_sleep_secs = s[15:0];
      i_sleep_cmd = 1;
      cyc(1);
      i_sleep_cmd = 0;
      cyc(1);
      n = 0;
      repeat (40) begin
         w = 0;
         while (o_low_power !== 1 && o_exec_en !== 1 && w < 60) begin
            cyc(1);
            w++;
         end
         if (o_exec_en === 1) break;
         tick();
         n++;
         cyc(8);
      end
      // Ticks needed: rounded-up steps over steps credited per tick
      exp_n = ((s * 1000 + 2303) / 2304 + per_tick - 1) / per_tick;
      check(n, exp_n);
      check(o_pin_dir, i_prog_dir);
   endtask : sleep_for
   initial begin
      {i_sleep_cmd, i_halt_cmd, i_wdt_tick, press} = 4'h0;
      i_sleep_secs = 16'h0000;
      i_prog_dir = 16'ha5c3;
      cyc(8);
      check(o_exec_en, 1);
      i_sleep_cmd = 1; // Zero seconds is ignored
      cyc(1);
      i_sleep_cmd = 0;
      cyc(4);
      check(o_exec_en, 1);
      repeat (4) secs_q.push_back(1 + ($unsigned($random(seed)) % 60));
      foreach (secs_q[k]) begin
         i_prog_dir = $random(seed);
         sleep_for(secs_q[k], 1);
      end
      tick(); // Two run ticks 200 cycles apart: double period measured
      cyc(199);
      tick();
      cyc(3);
      sleep_for(10, 2);
      {i_halt_cmd, i_sleep_cmd} = 2'h3; // Halt wins over sleep
      cyc(1);
      {i_halt_cmd, i_sleep_cmd} = 2'h0;
      cyc(2);
      check({o_halted, o_exec_en}, 2'h2);
      repeat (3) begin
         tick();
         i_sleep_cmd = 1;
         cyc(1);
         i_sleep_cmd = 0;
         cyc(20);
         check({o_halted, o_low_power}, 2'h2);
      end
      // Held over two falling edges so the pin model surely sees it
      press = 1;
      cyc(2);
      press = 0;
      cyc(8);
      check({o_halted, o_exec_en}, 2'h1);
      sleep_for(10, 1);
      test_done();
   end
   initial begin
      repeat (30000) @(posedge i_clock);
      fail_count++;
      test_done();
   end
endmodule : timed_sleep_and_halt_control_tb
`default_nettype wire
